// >>> src/mac_fc_pkg.sv
package mac_fc_pkg;

	// register byte offsets on the avalon slave
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_PAUSE_CTRL = 12'h01c;
	localparam logic [11:0] OFF_CNT_CTRL = 12'h100;
	localparam logic [11:0] OFF_HIDDEN_A = 12'h10c;
	localparam logic [11:0] OFF_HIDDEN_B = 12'h110;
	localparam logic [11:0] OFF_RX_ALL = 12'h200;
	localparam logic [11:0] OFF_TX_LONG = 12'h120;

	// reset values and writable-bit masks
	localparam logic [31:0] PAUSE_CTRL_RST = 32'h0050_0002;
	localparam logic [31:0] PAUSE_CTRL_MASK = 32'hffff_0002;
	localparam logic [31:0] CNT_CTRL_RST = 32'h0000_2f72;
	localparam logic [31:0] CNT_CTRL_MASK = 32'h0000_3ffa;
	localparam logic [31:0] HIDDEN_RST = 32'h0000_0000;

	// field positions
	localparam int PT_LSB = 16;
	localparam int FCE_BIT = 1;
	localparam int FCB_BIT = 0;
	localparam int MAX_FRAME_LENGTH_LSB = 3;
	localparam int MAX_FRAME_LENGTH_W = 11;

	// one pause quantum is 512 bit times, 5120 ns at 100 Mb/s
	localparam int CLK_PERIOD_NS = 10;
	localparam int SLOT_TIME_NS = 5120;
	localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic {PS_IDLE, PS_SEND} pause_st_t;

	// lowest byte address carries bits 31:24, so lanes are swapped end for end
	function automatic logic [31:0] byte_swap(input logic [31:0] v);
		byte_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : byte_swap

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		lane_merge = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				lane_merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : lane_merge

endpackage : mac_fc_pkg

// >>> src/mac_flow_stats.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
// Operation
// R1: a sent pause frame carries the 16-bit pause time from bits 31:16
// R2: with honour enable set, received pause frames stall the transmitter; enable resets to 1
// R3: writing 1 to the busy bit starts one pause frame; bit reads 1 meanwhile
// R4: busy bit clears itself once the pause frame is fully sent
// R5: software waits for busy to read 0 before asking another pause frame
// R6: 11-bit max frame length at bits 13:3; longer sent frames count as long
// R7: software must write 1 to bit 1 of the counter control word
// R8: software loads bytes 10ch to 10fh with ffh before operation
// R9: software loads bytes 110h to 113h with ffh before operation
// R10: received-frame count is 32 bits at 200h, bits 31:24 at the lowest byte
// R11: received-frame count adds one per frame, wraps, clears only on reset
// R12: after reset the max frame length reads 1518
module mac_flow_stats
	import mac_fc_pkg::*;
#(
	parameter int SLOT_LEN = SLOT_CYCLES
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pause frame transmit request
	output logic pause_tx_start,
	output logic [15:0] pause_slot_count,
	input wire logic pause_tx_done,
	// received pause frames and transmitter hold-off
	input wire logic rx_pause_valid,
	input wire logic [15:0] rx_pause_quanta,
	output logic tx_hold,
	// frame events
	input wire logic rx_frame_done,
	input wire logic tx_frame_done,
	input wire logic [13:0] tx_frame_len,
	// hidden control words
	output logic [31:0] hidden_ctrl_a,
	output logic [31:0] hidden_ctrl_b
);

	initial
	begin
		if (SLOT_LEN < 1 || SLOT_LEN > 65536)
		begin
			$error("SLOT_LEN out of range");
		end
	end

	localparam logic [15:0] SLOT_LAST = 16'(SLOT_LEN - 1);

	typedef struct packed {
		pause_st_t pst;
		logic [31:0] pause_ctrl;
		logic [31:0] cnt_ctrl;
		logic [31:0] hid_a;
		logic [31:0] hid_b;
		logic [31:0] rx_all;
		logic [31:0] tx_long;
		logic [15:0] hold_quanta;
		logic [15:0] slot_cnt;
		logic hold;
		logic start;
		logic [15:0] start_time;
		logic wrq;
		logic [31:0] rdata;
	} st_t;

	localparam st_t ST_RESET = '{
		pst: PS_IDLE,
		pause_ctrl: PAUSE_CTRL_RST,
		cnt_ctrl: CNT_CTRL_RST,
		hid_a: HIDDEN_RST,
		hid_b: HIDDEN_RST,
		rx_all: 32'h0000_0000,
		tx_long: 32'h0000_0000,
		hold_quanta: 16'h0000,
		slot_cnt: 16'h0000,
		hold: 1'b0,
		start: 1'b0,
		start_time: 16'h0000,
		wrq: 1'b1,
		rdata: 32'h0000_0000
	};

	st_t q;
	st_t d;

	logic req;
	logic wr_take;
	logic fcb_set;
	logic [31:0] wdata_s;
	logic [3:0] be_s;
	logic [31:0] rd_word;
	logic [MAX_FRAME_LENGTH_W-1:0] max_len;

	always_comb
	begin
		d = q;
		d.start = 1'b0;
		req = avs_read | avs_write;
		wdata_s = byte_swap(avs_writedata); // R10
		be_s = {avs_byteenable[0], avs_byteenable[1], avs_byteenable[2], avs_byteenable[3]};
		max_len = q.cnt_ctrl[MAX_FRAME_LENGTH_LSB +: MAX_FRAME_LENGTH_W];

		// read mux; unmapped addresses read zero
		unique case (avs_address)
			OFF_PAUSE_CTRL: rd_word = q.pause_ctrl | {31'h0, q.pst == PS_SEND}; // R3
			OFF_CNT_CTRL: rd_word = q.cnt_ctrl; // R12
			OFF_HIDDEN_A: rd_word = q.hid_a;
			OFF_HIDDEN_B: rd_word = q.hid_b;
			OFF_RX_ALL: rd_word = q.rx_all; // R10
			OFF_TX_LONG: rd_word = q.tx_long;
			default: rd_word = 32'h0000_0000;
		endcase

		// one wait cycle per access keeps readdata and waitrequest registered
		d.wrq = !(req && q.wrq);
		if (avs_read && q.wrq)
		begin
			d.rdata = byte_swap(rd_word); // R10
		end

		// pause frame completion first, so a same-cycle new request wins
		if (q.pst == PS_SEND && pause_tx_done)
		begin
			d.pst = PS_IDLE; // R4
		end

		wr_take = avs_write && !q.wrq;
		fcb_set = 1'b0;
		if (wr_take)
		begin
			unique case (avs_address)
				OFF_PAUSE_CTRL:
				begin
					d.pause_ctrl = lane_merge(q.pause_ctrl, wdata_s, be_s) & PAUSE_CTRL_MASK;
					fcb_set = be_s[0] && wdata_s[FCB_BIT];
				end
				OFF_CNT_CTRL: d.cnt_ctrl = lane_merge(q.cnt_ctrl, wdata_s, be_s) & CNT_CTRL_MASK; // R6
				OFF_HIDDEN_A: d.hid_a = lane_merge(q.hid_a, wdata_s, be_s);
				OFF_HIDDEN_B: d.hid_b = lane_merge(q.hid_b, wdata_s, be_s);
				default: d.hid_a = q.hid_a;
			endcase
		end

		// a request while busy is dropped unless pause_tx_done comes that cycle: software is expected to poll first
		if (fcb_set && (q.pst == PS_IDLE || pause_tx_done))
		begin
			d.pst = PS_SEND; // R3
			d.start = 1'b1; // R3
			d.start_time = d.pause_ctrl[PT_LSB +: 16]; // R1
		end

		if (rx_frame_done)
		begin
			d.rx_all = q.rx_all + 32'h0000_0001; // R11
		end

		if (tx_frame_done && tx_frame_len > {3'h0, max_len})
		begin
			d.tx_long = q.tx_long + 32'h0000_0001; // R6
		end

		// received pause: a new frame restarts the hold with its own quanta
		if (!q.pause_ctrl[FCE_BIT])
		begin
			d.hold = 1'b0; // R2
			d.hold_quanta = 16'h0000;
			d.slot_cnt = 16'h0000;
		end
		else if (rx_pause_valid)
		begin
			d.hold = rx_pause_quanta != 16'h0000; // R2
			d.hold_quanta = rx_pause_quanta; // R2
			d.slot_cnt = 16'h0000;
		end
		else if (q.hold)
		begin
			if (q.slot_cnt == SLOT_LAST)
			begin
				d.slot_cnt = 16'h0000;
				d.hold_quanta = q.hold_quanta - 16'h0001; // R2
				d.hold = q.hold_quanta != 16'h0001; // R2
			end
			else
			begin
				d.slot_cnt = q.slot_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= ST_RESET; // R11
		end
		else
		begin
			q <= d;
		end
	end

	assign avs_readdata = q.rdata;
	assign avs_waitrequest = q.wrq;
	assign pause_tx_start = q.start;
	assign pause_slot_count = q.start_time;
	assign tx_hold = q.hold;
	assign hidden_ctrl_a = q.hid_a;
	assign hidden_ctrl_b = q.hid_b;

endmodule : mac_flow_stats

// >>> bench/mac_flow_stats_asserts.sv
`timescale 1ns/1ps
module mac_flow_stats_asserts(
	input wire logic clk, rst, avs_read, avs_write, avs_waitrequest,
	input wire logic pause_tx_start, pause_tx_done, rx_pause_valid, tx_hold,
	input wire logic [15:0] pause_slot_count, rx_pause_quanta
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_wait_one: assert property ((avs_read|avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no ack after one wait");
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack longer than one cycle");
	chk_wait_idle: assert property (!(avs_read|avs_write) |=> avs_waitrequest)
		else $error("ack without request");
	chk_start_once: assert property (
		pause_tx_start |=> (!pause_tx_start until pause_tx_done)) else $error("second start");
	chk_slot_hold: assert property (!pause_tx_start |-> $stable(pause_slot_count))
		else $error("slot count moved");
	chk_hold_set: assert property (rx_pause_valid && rx_pause_quanta != 0 |=> tx_hold)
		else $error("hold not raised");
	chk_hold_clear: assert property (rx_pause_valid && rx_pause_quanta == 0 |=> !tx_hold)
		else $error("hold not cleared");
	chk_hold_min: assert property (
		$rose(tx_hold) ##0 (!rx_pause_valid)[*3] |=> tx_hold) else $error("hold too short");
endmodule : mac_flow_stats_asserts
bind mac_flow_stats mac_flow_stats_asserts i_mac_flow_stats_asserts (.*);

// >>> bench/mac_pause_peer.sv
`timescale 1ns/1ps
// reports a pause frame fully sent some cycles after the request
module mac_pause_peer(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [3:0] dly,
	output logic done
);
	int n = 0;
	// one assignment per signal per edge, so done never glitches inside a time step
	always @(posedge clk)
	begin
		if (rst)
		begin
			n <= 0;
			done <= 1'b0;
		end
		else
		begin
			done <= n == 1;
			if (start)
				n <= dly + 1;
			else if (n > 0)
				n <= n - 1;
		end
	end
endmodule : mac_pause_peer

// >>> bench/test_mac_flow_stats.sv
`timescale 1ns/1ps
module test_mac_flow_stats
	import mac_fc_pkg::*;
;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, pause_tx_start;
	logic pause_tx_done, rx_pause_valid = 0, tx_hold, rx_frame_done = 0, tx_frame_done = 0;
	logic [11:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, hidden_ctrl_a, hidden_ctrl_b;
	logic [31:0] r = 32'h1ec9, eq[$], pq[$];
	logic [15:0] pause_slot_count, rx_pause_quanta = 0;
	logic [13:0] tx_frame_len = 0;
	int n_mismatch = 0, checks = 0, cyc = 0, k;
	always #5 clk = ~clk;
	mac_flow_stats #(.SLOT_LEN(4)) i_mac_flow_stats (.*, .avs_byteenable(4'hf));
	mac_pause_peer i_mac_pause_peer (.clk, .rst, .start(pause_tx_start), .dly(r[3:0] | 4'h8),
		.done(pause_tx_done));
	function automatic logic [31:0] sw(input logic [31:0] v);
		sw = {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : sw
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= sw(d);
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		eq.push_back(e);
		bus(0, a, 0);
	endtask : rd
	task complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// the watcher pairs each acked read or pause start with the oldest note
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			complete_run;
		end
		if (avs_read && avs_waitrequest === 1'b0)
			cmp("readdata", sw(eq.pop_front()), avs_readdata);
		if (pause_tx_start === 1'b1)
			cmp("slot count", pq.pop_front(), {16'h0, pause_slot_count});
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(12'h01c, 32'h0050_0002);
		rd(12'h100, 32'h0000_2f72);
		rd(12'h0f0, 0);
		bus(1, 12'h100, 32'h0000_0322);
		rd(12'h100, 32'h0000_0322);
		tx_frame_len <= 14'd101;
		tx_frame_done <= 1;
		@(posedge clk);
		tx_frame_len <= 14'd100;
		@(posedge clk);
		tx_frame_done <= 0;
		rd(12'h120, 1);
		bus(1, 12'h10c, '1);
		bus(1, 12'h110, '1);
		rd(12'h110, '1);
		cmp("hidden a", '1, hidden_ctrl_a);
		cmp("hidden b", '1, hidden_ctrl_b);
		r = lfsr(r);
		repeat (r[2:0] + 1)
		begin
			rx_frame_done <= 1;
			@(posedge clk);
		end
		rx_frame_done <= 0;
		rd(12'h200, r[2:0] + 1);
		rd(12'h01c, 32'h0050_0002);
		for (k = 0; k < 2; k++)
		begin
			r = lfsr(r);
			pq.push_back({16'h0, r[31:16]});
			bus(1, 12'h01c, {r[31:16], 16'h0003});
			bus(1, 12'h01c, {r[31:16], 16'h0003});
			rd(12'h01c, {r[31:16], 16'h0003});
			repeat (20) @(posedge clk);
			rd(12'h01c, {r[31:16], 16'h0002});
		end
		// two quanta of four cycles: hold high for eight cycles, then low
		rx_pause_quanta <= 16'h0002;
		rx_pause_valid <= 1;
		@(posedge clk);
		rx_pause_valid <= 0;
		@(posedge clk);
		cmp("hold", 1, tx_hold);
		repeat (8) @(posedge clk);
		cmp("hold", 0, tx_hold);
		// a zero-quanta frame cuts a running hold short
		rx_pause_valid <= 1;
		@(posedge clk);
		rx_pause_quanta <= 16'h0000;
		@(posedge clk);
		rx_pause_valid <= 0;
		@(posedge clk);
		cmp("hold", 0, tx_hold);
		repeat (4) @(posedge clk);
		complete_run;
	end
endmodule : test_mac_flow_stats
